// >>> logic/sqdc_map.vh
// Purpose: constants for the squib driver diagnostic command logic
// Assumes: 8-bit spi frames, command decoded on chip select rise
// Notes: all codes and timing counts live here
// Function
// [RULE1] current-limit status query reports comparator per channel
// [RULE2] measurement captured on next valid command
// [RULE3] status bit follows current above threshold
// [RULE4] reset command clears selected channel registers
// [RULE5] no thermal shutdown before minimum on-time
// [RULE6] one channel shutdown leaves others firing
// [RULE7] thermal bits set, query latches them
// [RULE8] latched thermal shifted next frame, then cleared
// [RULE9] rearm only once thermal status is zero
// [RULE10] host sends unlock then selection, enables low
// [RULE11] unlock accepted only with both enables low
// [RULE12] unlock code echoed during next frame
// [RULE13] enabled firing aborts any transistor test
// [RULE14] unlock clears diagnostics, second frame restores
// [RULE15] high-side byte low nibble selects drivers
// [RULE16] low-side byte low nibble selects drivers
// [RULE17] test current limited, host times the test
// [RULE18] either unlock stops previous transistor test
// [RULE19] test fail bit one if driver stayed off
// [RULE20] test status shifted out next frame
// [RULE21] unlock load clears test status register
// [RULE22] any sequence of selection codes accepted
// [RULE23] reset clears shift registers and pending tests
// [RULE24] reset clears current-limit timing registers
// [RULE25] eight-bit frames decoded on chip select rise
`ifndef SQDC_MAP_VH
`define SQDC_MAP_VH
`define SQDC_CMD_CL_STATUS   8'h79
`define SQDC_CMD_THERM_QUERY 8'h7F
`define SQDC_CMD_CL_RESET    4'h3
`define SQDC_CMD_HS_UNLOCK   8'h82
`define SQDC_CMD_LS_UNLOCK   8'h83
`define SQDC_CMD_HS_SELECT   4'h1
`define SQDC_CMD_LS_SELECT   4'h2
`define SQDC_CMD_NOP         8'h00
`define SQDC_MIN_ON_US       2090
`define SQDC_CLK_MHZ         25
`define SQDC_MIN_ON_CYC      (`SQDC_MIN_ON_US * `SQDC_CLK_MHZ)
`define SQDC_RESET_BYTE      8'h00
`endif

// >>> logic/sqdc_core.v
// Purpose: spi command logic for current limit, thermal, fet tests
// Assumes: spi mode 0, msb first, pins synchronised to clk_sys here
// Notes: analogue comparators arrive as levels and are synchronised
`timescale 1ns/10ps
`include "sqdc_map.vh"
module sqdc_core #(
  parameter CH        = 4,
  parameter MIN_ON_CY = `SQDC_MIN_ON_CYC
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rst,
  // spi pins
  input  wire          spiSclk,
  input  wire          spiCsN,
  input  wire          spiMosi,
  output reg           spiMiso,
  output reg           spiMisoOeN,
  // firing enables
  input  wire          fire_enable_in_a,
  input  wire          fire_enable_in_b,
  // analogue status, one bit per channel
  input  wire [CH-1:0] current_measure_threshold,
  input  wire [CH-1:0] driverOn,
  input  wire [CH-1:0] thermalOver,
  input  wire [CH-1:0] thermal_reenable_level,
  input  wire [CH-1:0] channel_sense_input,
  // driver controls and status
  output reg  [CH-1:0] channel_high_output,
  output reg  [CH-1:0] lowSideTestOn,
  output reg  [CH-1:0] thermalShutdown,
  output reg  [CH-1:0] armAllowed,
  output reg           diagEnabled,
  output reg  [CH-1:0] high_side_test_fail_bit,
  output reg  [CH-1:0] low_side_test_fail_bit
);
  localparam ST_IDLE   = 3'b001;
  localparam ST_HSWAIT = 3'b010;
  localparam ST_LSWAIT = 3'b100;

  reg  [2:0]    sclkSync;
  reg  [2:0]    csSync;
  reg  [1:0]    mosiSync;
  reg  [1:0]    fenASync;
  reg  [1:0]    fenBSync;
  reg  [CH-1:0] imeasS1;
  reg  [CH-1:0] imeasS2;
  reg  [CH-1:0] onS1;
  reg  [CH-1:0] onS2;
  reg  [CH-1:0] thS1;
  reg  [CH-1:0] thS2;
  reg  [CH-1:0] reenS1;
  reg  [CH-1:0] reenS2;
  reg  [CH-1:0] senseS1;
  reg  [CH-1:0] senseS2;
  reg  [7:0]    rxShift;
  reg  [7:0]    txShift;
  reg  [3:0]    bitCnt;
  reg  [2:0]    state;
  reg  [CH-1:0] clStatus;
  reg  [CH-1:0] clPending;
  reg  [CH-1:0] thermalRaw;
  reg  [CH-1:0] thermalLatch;
  reg           thermalShown;
  reg  [7:0]    nextTx;
  reg  [2:0]    next_state;
  wire          sclkRise;
  wire          sclkFall;
  wire          csRise;
  wire          csFall;
  wire          fireEn;
  wire          testUnlockOk;
  wire          frameOk;
  wire          frameDone;
  wire          testActive;

  assign sclkRise     = sclkSync[1] & ~sclkSync[2];
  assign sclkFall     = ~sclkSync[1] & sclkSync[2];
  assign csRise       = csSync[1] & ~csSync[2];
  assign csFall       = ~csSync[1] & csSync[2];
  assign fireEn       = fenASync[1] | fenBSync[1];
  assign testUnlockOk = ~fenASync[1] & ~fenBSync[1];  // [RULE11]
  assign frameOk      = (bitCnt == 4'h8);              // [RULE25]
  assign frameDone    = csRise & frameOk;
  assign testActive   = |(channel_high_output | lowSideTestOn);

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      sclkSync <= 3'b000;
      csSync   <= 3'b111;
      mosiSync <= 2'b00;
      fenASync <= 2'b00;
      fenBSync <= 2'b00;
      imeasS1  <= {CH{1'b0}};
      imeasS2  <= {CH{1'b0}};
      onS1     <= {CH{1'b0}};
      onS2     <= {CH{1'b0}};
      thS1     <= {CH{1'b0}};
      thS2     <= {CH{1'b0}};
      reenS1   <= {CH{1'b0}};
      reenS2   <= {CH{1'b0}};
      senseS1  <= {CH{1'b0}};
      senseS2  <= {CH{1'b0}};
    end
    else
    begin
      sclkSync <= {sclkSync[1:0], spiSclk};
      csSync   <= {csSync[1:0], spiCsN};
      mosiSync <= {mosiSync[0], spiMosi};
      fenASync <= {fenASync[0], fire_enable_in_a};
      fenBSync <= {fenBSync[0], fire_enable_in_b};
      imeasS1  <= current_measure_threshold;
      imeasS2  <= imeasS1;
      onS1     <= driverOn;
      onS2     <= onS1;
      thS1     <= thermalOver;
      thS2     <= thS1;
      reenS1   <= thermal_reenable_level;
      reenS2   <= reenS1;
      senseS1  <= channel_sense_input;
      senseS2  <= senseS1;
    end
  end

  // per-channel on-time guard: each channel counts alone, so a shutdown
  // on one never touches the others
  genvar g;
  generate
    for (g = 0; g < CH; g = g + 1)
    begin : gCh
      reg [31:0] onCnt;
      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          onCnt              <= 32'h00000000;
          thermalRaw[g]      <= 1'b0;
          thermalShutdown[g] <= 1'b0;
          armAllowed[g]      <= 1'b1;
        end
        else
        begin
          if (!onS2[g])
            onCnt <= 32'h00000000;
          else if (onCnt < MIN_ON_CY)
            onCnt <= onCnt + 32'h00000001;
          // over-temperature only honoured past the minimum on-time
          if (thS2[g] && onS2[g] && onCnt >= MIN_ON_CY)   // [RULE5] [RULE6]
          begin
            thermalRaw[g]      <= 1'b1;                   // [RULE7]
            thermalShutdown[g] <= 1'b1;
          end
          else if (reenS2[g] && !thS2[g])
          begin
            thermalRaw[g]      <= 1'b0;
            thermalShutdown[g] <= 1'b0;
          end
          armAllowed[g] <= ~thermalRaw[g];                 // [RULE9]
        end
      end
    end
  endgenerate

  always @*
  begin
    next_state = state;
    nextTx     = `SQDC_RESET_BYTE;
    if (rxShift == `SQDC_CMD_CL_STATUS)
      nextTx = {{(8-CH){1'b0}}, clStatus};                  // [RULE1]
    else if (rxShift == `SQDC_CMD_THERM_QUERY)
      nextTx = {{(8-CH){1'b0}}, thermalRaw};                // [RULE7]
    case (state)
      ST_IDLE:
      begin
        if (rxShift == `SQDC_CMD_HS_UNLOCK && testUnlockOk)
          next_state = ST_HSWAIT;
        else if (rxShift == `SQDC_CMD_LS_UNLOCK && testUnlockOk)
          next_state = ST_LSWAIT;
      end
      ST_HSWAIT: next_state = ST_IDLE;
      ST_LSWAIT: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
    if ((rxShift == `SQDC_CMD_HS_UNLOCK || rxShift == `SQDC_CMD_LS_UNLOCK)
        && testUnlockOk)
      nextTx = rxShift;                                     // [RULE12]
    else if (state != ST_IDLE ||
             (testActive && rxShift == `SQDC_CMD_NOP))
      nextTx = {{(8-CH){1'b0}}, high_side_test_fail_bit
               | low_side_test_fail_bit};                   // [RULE20]
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      // shift registers and pending tests all cleared
      rxShift                 <= 8'h00;                     // [RULE23]
      txShift                 <= 8'h00;
      bitCnt                  <= 4'h0;
      state                   <= ST_IDLE;
      spiMiso                 <= 1'b0;
      spiMisoOeN              <= 1'b1;
      clStatus                <= {CH{1'b0}};                // [RULE24]
      clPending               <= {CH{1'b0}};
      channel_high_output     <= {CH{1'b0}};
      lowSideTestOn           <= {CH{1'b0}};
      diagEnabled             <= 1'b1;
    end
    else
    begin
      spiMisoOeN <= csSync[1];
      // comparator result resampled every cycle until the next valid command copies it
      clPending  <= imeasS2;                                // [RULE3]
      if (csFall)
      begin
        bitCnt  <= 4'h0;
        spiMiso <= txShift[7];
      end
      if (!csSync[1] && sclkRise && bitCnt != 4'hF)
      begin
        rxShift <= {rxShift[6:0], mosiSync[1]};
        bitCnt  <= bitCnt + 4'h1;
      end
      if (!csSync[1] && sclkFall)
      begin
        txShift <= {txShift[6:0], 1'b0};
        spiMiso <= txShift[6];
      end
      // tests time themselves only by the host; current limit is analogue
      if (fireEn)
      begin
        channel_high_output <= {CH{1'b0}};                  // [RULE13]
        lowSideTestOn       <= {CH{1'b0}};
      end
      if (csRise && frameOk)
      begin
        txShift <= nextTx;
        state   <= next_state;
        clStatus <= clPending;                              // [RULE2]
        if (rxShift[7:4] == `SQDC_CMD_CL_RESET)
          clStatus <= clPending & ~rxShift[CH-1:0];         // [RULE4]
        if (next_state != ST_IDLE)
        begin
          channel_high_output     <= {CH{1'b0}};            // [RULE18]
          lowSideTestOn           <= {CH{1'b0}};
          diagEnabled             <= 1'b0;                  // [RULE14]
        end
        if (state != ST_IDLE)
          diagEnabled <= 1'b1;                              // [RULE14]
        if (state == ST_HSWAIT && !fireEn &&
            rxShift[7:4] == `SQDC_CMD_HS_SELECT)
          channel_high_output <= rxShift[CH-1:0];           // [RULE15] [RULE22]
        if (state == ST_LSWAIT && !fireEn &&
            rxShift[7:4] == `SQDC_CMD_LS_SELECT)
          lowSideTestOn <= rxShift[CH-1:0];                 // [RULE16] [RULE17]
      end
      if (csRise && !frameOk)
        txShift <= 8'h00;
      // firing drops a half-done unlock so no select can follow it
      if (fireEn && state != ST_IDLE)
      begin
        state       <= ST_IDLE;                             // [RULE13]
        diagEnabled <= 1'b1;
      end
    end
  end

  // failures stick until the next unlock so a brief off reading of sense or driverOn is not lost
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      high_side_test_fail_bit <= {CH{1'b0}};
      low_side_test_fail_bit  <= {CH{1'b0}};
    end
    else if (frameDone && next_state != ST_IDLE)
    begin
      high_side_test_fail_bit <= {CH{1'b0}};                // [RULE21]
      low_side_test_fail_bit  <= {CH{1'b0}};
    end
    else if (state == ST_IDLE)
    begin
      high_side_test_fail_bit <= high_side_test_fail_bit
                                 | (channel_high_output & ~senseS2);
      low_side_test_fail_bit  <= low_side_test_fail_bit
                                 | (lowSideTestOn & ~onS2); // [RULE19]
    end
  end

  // the query reply is loaded at decode, so the latch only marks the
  // frame whose end must clear it
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      thermalLatch <= {CH{1'b0}};
      thermalShown <= 1'b0;
    end
    else if (frameDone)
    begin
      if (rxShift == `SQDC_CMD_THERM_QUERY)
      begin
        thermalLatch <= thermalRaw;                         // [RULE7]
        thermalShown <= 1'b1;
      end
      else if (thermalShown)
      begin
        thermalLatch <= {CH{1'b0}};                         // [RULE8]
        thermalShown <= 1'b0;
      end
    end
  end
endmodule

// >>> verif/sqdc_props_properties.sv
// Purpose: port properties of the squib diagnostic command logic
// Assumes: bound to sqdc_core, sync reset rst active high
// Notes: firing enables cross a two-stage synchroniser
`timescale 1ns/10ps
module sqdc_props #(
  parameter CH = 4
) (
  // clock and reset
  input wire          clk_sys,
  input wire          rst,
  // pins
  input wire          spiCsN,
  input wire          spiMisoOeN,
  input wire          fire_enable_in_a,
  input wire          fire_enable_in_b,
  // driver controls and status
  input wire [CH-1:0] channel_high_output,
  input wire [CH-1:0] lowSideTestOn,
  input wire [CH-1:0] thermalShutdown,
  input wire [CH-1:0] armAllowed,
  input wire          diagEnabled,
  input wire [CH-1:0] high_side_test_fail_bit,
  input wire [CH-1:0] low_side_test_fail_bit
);
  wire          fen = fire_enable_in_a | fire_enable_in_b;
  wire [CH-1:0] tst = channel_high_output | lowSideTestOn;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_abort; fen[*5] |-> tst == 0; endproperty
  a_abort: assert property (p_abort)
    else $error("test left on with firing enabled");
  property p_excl; !(|channel_high_output && |lowSideTestOn); endproperty
  a_excl: assert property (p_excl)
    else $error("high and low side tests on together");
  property p_rst;
    disable iff (1'b0) rst |=> tst == 0 && spiMisoOeN && diagEnabled;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset left a test or driver on");
  property p_idle; spiCsN[*4] |-> spiMisoOeN; endproperty
  a_idle: assert property (p_idle)
    else $error("data out driven outside a frame");
  property p_arm;
    |thermalShutdown |=> (armAllowed & $past(thermalShutdown)) == 0;
  endproperty
  a_arm: assert property (p_arm)
    else $error("arm allowed during thermal shutdown");
  property p_clr;
    $fell(diagEnabled) |-> ##[0:2] (tst == 0 &&
      (high_side_test_fail_bit | low_side_test_fail_bit) == 0);
  endproperty
  a_clr: assert property (p_clr)
    else $error("unlock did not clear tests and status");
  property p_hsfail;
    (high_side_test_fail_bit & ~$past(high_side_test_fail_bit) &
     ~(channel_high_output | $past(channel_high_output))) == 0;
  endproperty
  a_hsfail: assert property (p_hsfail)
    else $error("high side fail set on untested channel");
  property p_lsfail;
    (low_side_test_fail_bit & ~$past(low_side_test_fail_bit) &
     ~(lowSideTestOn | $past(lowSideTestOn))) == 0;
  endproperty
  a_lsfail: assert property (p_lsfail)
    else $error("low side fail set on untested channel");
  property p_lock; fen[*6] |=> diagEnabled; endproperty
  a_lock: assert property (p_lock)
    else $error("unlock taken with firing enabled");
endmodule
bind sqdc_core sqdc_props #(.CH(CH)) u_props (
  .clk_sys(clk_sys), .rst(rst), .spiCsN(spiCsN), .spiMisoOeN(spiMisoOeN),
  .fire_enable_in_a(fire_enable_in_a), .fire_enable_in_b(fire_enable_in_b),
  .channel_high_output(channel_high_output), .lowSideTestOn(lowSideTestOn),
  .thermalShutdown(thermalShutdown), .armAllowed(armAllowed),
  .diagEnabled(diagEnabled),
  .high_side_test_fail_bit(high_side_test_fail_bit),
  .low_side_test_fail_bit(low_side_test_fail_bit));

// >>> verif/sqdc_host.sv
// Purpose: host spi master model, mode 0, msb first
// Assumes: sclk period 320 ns, eight clk_sys cycles
// Notes: sclk stands low between frames
`timescale 1ns/10ps
module sqdc_host (
  // clock
  input wire clk_sys,
  // spi pins
  input wire spiMiso,
  output reg spiSclk,
  output reg spiCsN,
  output reg spiMosi
);
  initial
  begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end
  // nb other than 8 only for refused frames
  task xfer(input [7:0] tx, input integer nb, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      spiCsN <= 1'b0;
      repeat (8) @(posedge clk_sys);
      for (i = nb - 1; i >= 0; i = i - 1)
      begin
        spiMosi <= tx[i];
        repeat (4) @(posedge clk_sys);
        spiSclk <= 1'b1;
        rx = {rx[6:0], spiMiso};
        repeat (4) @(posedge clk_sys);
        spiSclk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      spiCsN <= 1'b1;
      // released line must not keep the last bit
      spiMosi <= ~spiMosi;
      repeat (8) @(posedge clk_sys);
    end
  endtask
endmodule

// >>> verif/sqdc_core_tb_top.sv
// Purpose: self-checking bench for sqdc_core
// Assumes: MIN_ON_CY shortened to 20 cycles
// Notes: test fail feedback from sense and driverOn levels
`timescale 1ns/10ps
module sqdc_core_tb_top;
  reg        clk_sys, rst, fenA, fenB;
  reg  [3:0] thr, drvOn, tOver, reen, sense, m, s;
  reg  [7:0] rx;
  wire       sclk, csN, mosi, miso, misoOeN, diagEn;
  wire [3:0] hsOn, lsOn, tShut, arm, hsFail, lsFail;
  integer    mismatches, compares, i;
  sqdc_core #(.CH(4), .MIN_ON_CY(20)) dut (
    .clk_sys(clk_sys), .rst(rst), .spiSclk(sclk), .spiCsN(csN),
    .spiMosi(mosi), .spiMiso(miso), .spiMisoOeN(misoOeN),
    .fire_enable_in_a(fenA), .fire_enable_in_b(fenB),
    .current_measure_threshold(thr), .driverOn(drvOn),
    .thermalOver(tOver), .thermal_reenable_level(reen),
    .channel_sense_input(sense), .channel_high_output(hsOn),
    .lowSideTestOn(lsOn), .thermalShutdown(tShut), .armAllowed(arm),
    .diagEnabled(diagEn), .high_side_test_fail_bit(hsFail),
    .low_side_test_fail_bit(lsFail));
  sqdc_host h (.clk_sys(clk_sys), .spiMiso(miso), .spiSclk(sclk),
    .spiCsN(csN), .spiMosi(mosi));
  function [7:0] failExp(input [3:0] mask, input [3:0] seen);
    failExp = {4'h0, mask & ~seen};
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial
  begin
    mismatches = 0;
    compares = 0;
    {rst, fenA, fenB} = 3'b100;
    {thr, drvOn, tOver, reen, sense} = 20'h00000;
    i = $urandom(32'h86F9);
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({hsOn, lsOn}, 8'h00);
    chk({arm, 2'h0, misoOeN, diagEn}, 8'hF3);
    $display("test reset done");
    for (i = 0; i < 6; i = i + 1)
    begin
      m = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : $urandom;
      s = $urandom;
      sense <= s;
      drvOn <= s;
      h.xfer(8'h82, 8, rx);
      chk({7'h0, diagEn}, 8'h00);
      chk({lsOn, hsFail}, 8'h00);
      h.xfer({4'h1, m}, 8, rx);
      chk(rx, 8'h82);
      chk({diagEn, 3'h0, hsOn}, {4'h8, m});
      h.xfer(8'h00, 8, rx);
      chk(rx, 8'h00);
      h.xfer(8'h00, 8, rx);
      chk(rx, failExp(m, s));
      h.xfer(8'h83, 8, rx);
      chk({hsOn, hsFail}, 8'h00);
      h.xfer({4'h2, m}, 8, rx);
      chk(rx, 8'h83);
      chk({4'h0, lsOn}, {4'h0, m});
      h.xfer(8'h00, 8, rx);
      chk(rx, 8'h00);
      h.xfer(8'h00, 8, rx);
      chk(rx, failExp(m, s));
    end
    $display("test transistor done");
    fenA <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk({hsOn, lsOn}, 8'h00);
    {fenA, fenB} <= 2'b01;
    h.xfer(8'h82, 8, rx);
    h.xfer(8'h1F, 8, rx);
    chk({3'h0, diagEn, hsOn}, 8'h10);
    fenB <= 1'b0;
    h.xfer(8'h82, 7, rx);
    h.xfer(8'h1F, 8, rx);
    chk({3'h0, diagEn, hsOn}, 8'h10);
    $display("test refusal done");
    s = $urandom;
    {drvOn, tOver} <= {4'hF, s};
    repeat (10) @(posedge clk_sys);
    chk({4'h0, tShut}, 8'h00);
    repeat (30) @(posedge clk_sys);
    chk({arm, tShut}, {~s, s});
    h.xfer(8'h7F, 8, rx);
    h.xfer(8'h00, 8, rx);
    chk(rx, {4'h0, s});
    h.xfer(8'h00, 8, rx);
    chk(rx, 8'h00);
    {drvOn, tOver, reen} <= 12'h00F;
    repeat (10) @(posedge clk_sys);
    chk({4'h0, arm}, 8'h0F);
    $display("test thermal done");
    s = $urandom;
    thr <= s;
    h.xfer(8'h00, 8, rx);
    h.xfer(8'h79, 8, rx);
    h.xfer(8'h00, 8, rx);
    chk(rx, {4'h0, s});
    m = $urandom;
    h.xfer({4'h3, m}, 8, rx);
    h.xfer(8'h79, 8, rx);
    h.xfer(8'h00, 8, rx);
    chk(rx, {4'h0, s & ~m});
    $display("test current limit done");
    wrap_up;
  end
endmodule
